// ---- design/ubw_pkg.sv ----
`default_nettype none
package ubw_pkg;
  // Register byte offsets on the Avalon-MM slave
  localparam logic [4:0] OFS_MODE0 = 5'h00;
  localparam logic [4:0] OFS_CTL = 5'h04;
  localparam logic [4:0] OFS_DATA = 5'h08;
  localparam logic [4:0] OFS_MODE2 = 5'h0C;
  localparam logic [4:0] OFS_BAUD = 5'h10;
  localparam logic [4:0] OFS_STAT = 5'h14;
  localparam logic [4:0] OFS_MASK = 5'h18;
  // serial_mode_ctl0 fields
  localparam int M0_SEL_LO = 0;
  localparam int M0_WAKE = 4;
  localparam int M0_TX9 = 7;
  // serial_ctl fields
  localparam int CT_PAR_EN = 0;
  localparam int CT_EVEN = 1;
  localparam int CT_PERR = 2;
  localparam int CT_FERR = 3;
  localparam int CT_RX9 = 7;
  // serial_mode_ctl2 fields
  localparam int M2_STOP = 0;
  localparam int M2_OD = 1;
  localparam int M2_BUSY = 2;
  // Interrupt status and mask bits
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX = 1;
  localparam int IRQ_ERR = 2;
  localparam int IRQ_W = 3;
  // frame_mode_sel codes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_8BIT = 2'h2;
  localparam logic [1:0] MODE_9BIT = 2'h3;
  // Reset values and base frame length in bits
  localparam logic [15:0] BAUD_RST = 16'h0010;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic [3:0] FRAME_BASE_BITS = 4'hA;

  typedef enum logic [1:0] {
    UBW_RX_IDLE = 2'b00,
    UBW_RX_START = 2'b01,
    UBW_RX_BITS = 2'b10,
    UBW_RX_STOP = 2'b11
  } ubw_rx_e;

  // Parity bit for even (total ones even) or odd parity
  function automatic logic parity_bit(input logic [7:0] d, input logic even);
    parity_bit = even ? ^d : ~^d;
  endfunction
endpackage
`default_nettype wire

// ---- design/ubw_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface ubw_link_if;
  logic dev_tx_out;
  logic dev_tx_oe;
  logic far_tx_out;
  logic far_tx_oe;
  logic dev_rx;
  logic far_rx;
  // Lines idle high through a pull-up when nobody drives them
  assign dev_rx = far_tx_oe ? far_tx_out : 1'b1;
  assign far_rx = dev_tx_oe ? dev_tx_out : 1'b1;
  modport dev (output dev_tx_out, output dev_tx_oe, input dev_rx);
  modport far (output far_tx_out, output far_tx_oe, input far_rx);
endinterface
`default_nettype wire

// ---- design/ubw_frame.sv ----
`timescale 1ns/1ps
`default_nettype none
module ubw_frame (
  input wire logic mclk, // Clock
  input wire logic reset, // Async reset
  input wire logic [15:0] div, // Clocks per bit
  input wire logic nine, // 9-bit framing
  input wire logic par_en, // Parity in 8-bit framing
  input wire logic par_even, // Even parity
  input wire logic stop2, // Two stop bits
  input wire logic tx_start, // Start pulse
  input wire logic [8:0] tx_data, // Data, bit 8 is ninth bit
  output logic tx_busy, // Frame in flight
  output logic txd, // Serial output level
  input wire logic rx_pin, // Serial input pin
  output logic rx_done, // Frame received pulse
  output logic [8:0] rx_data, // Received data, bit 8 ninth bit
  output logic rx_perr, // Parity error
  output logic rx_ferr // Framing error
);
  logic extra;
  logic tx_x;
  logic [10:0] tx_sh_q;
  logic [3:0] tx_left_q;
  logic [15:0] tx_cnt_q;
  logic rx_s1_q;
  logic rx_s2_q;
  ubw_pkg::ubw_rx_e rx_st_q;
  logic [15:0] rx_cnt_q;
  logic [3:0] rx_n_q;
  logic [8:0] rx_sh_q;

  assign extra = nine | par_en;
  assign tx_x = nine ? tx_data[8] : ubw_pkg::parity_bit(tx_data[7:0], par_even);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tx_busy <= 1'b0;
      txd <= 1'b1;
      tx_sh_q <= 11'h7FF;
      tx_left_q <= 4'h0;
      tx_cnt_q <= 16'h0000;
    end else if (!tx_busy) begin
      if (tx_start) begin
        tx_busy <= 1'b1;
        txd <= 1'b0;
        tx_sh_q <= {2'h3, extra ? tx_x : 1'b1, tx_data[7:0]};
        tx_left_q <= ubw_pkg::FRAME_BASE_BITS + {3'h0, extra} + {3'h0, stop2};
        tx_cnt_q <= div - 16'h0001;
      end
    end else if (tx_cnt_q != 16'h0000) begin
      tx_cnt_q <= tx_cnt_q - 16'h0001;
    end else begin
      tx_cnt_q <= div - 16'h0001;
      if (tx_left_q == 4'h1) begin
        tx_busy <= 1'b0;
        txd <= 1'b1;
      end else begin
        txd <= tx_sh_q[0];
        tx_sh_q <= {1'b1, tx_sh_q[10:1]};
        tx_left_q <= tx_left_q - 4'h1;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= rx_pin;
      rx_s2_q <= rx_s1_q;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rx_st_q <= ubw_pkg::UBW_RX_IDLE;
      rx_cnt_q <= 16'h0000;
      rx_n_q <= 4'h0;
      rx_sh_q <= 9'h000;
      rx_done <= 1'b0;
      rx_data <= 9'h000;
      rx_perr <= 1'b0;
      rx_ferr <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      unique case (rx_st_q)
        ubw_pkg::UBW_RX_IDLE: begin
          if (!rx_s2_q) begin
            rx_cnt_q <= {1'b0, div[15:1]};
            rx_st_q <= ubw_pkg::UBW_RX_START;
          end
        end
        ubw_pkg::UBW_RX_START: begin
          if (rx_cnt_q != 16'h0000) begin
            rx_cnt_q <= rx_cnt_q - 16'h0001;
          end else if (!rx_s2_q) begin
            // Start still low at mid-bit: a real frame, not a glitch
            rx_cnt_q <= div - 16'h0001;
            rx_n_q <= 4'h0;
            rx_st_q <= ubw_pkg::UBW_RX_BITS;
          end else begin
            rx_st_q <= ubw_pkg::UBW_RX_IDLE;
          end
        end
        ubw_pkg::UBW_RX_BITS: begin
          if (rx_cnt_q != 16'h0000) begin
            rx_cnt_q <= rx_cnt_q - 16'h0001;
          end else begin
            rx_cnt_q <= div - 16'h0001;
            rx_sh_q <= {rx_s2_q, rx_sh_q[8:1]};
            rx_n_q <= rx_n_q + 4'h1;
            // Last sample is data bit 7, or the extra bit when present
            if (rx_n_q == 4'h7 + {3'h0, extra}) begin
              rx_st_q <= ubw_pkg::UBW_RX_STOP;
            end
          end
        end
        ubw_pkg::UBW_RX_STOP: begin
          if (rx_cnt_q != 16'h0000) begin
            rx_cnt_q <= rx_cnt_q - 16'h0001;
          end else begin
            rx_done <= 1'b1;
            rx_ferr <= !rx_s2_q;
            rx_data <= nine ? rx_sh_q : {1'b0, extra ? rx_sh_q[7:0] : rx_sh_q[8:1]};
            rx_perr <= par_en && !nine &&
                       (rx_sh_q[8] != ubw_pkg::parity_bit(rx_sh_q[7:0], par_even));
            rx_st_q <= ubw_pkg::UBW_RX_IDLE;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- design/ubw_far.sv ----
`timescale 1ns/1ps
`default_nettype none
module ubw_far (
  input wire logic mclk, // Clock
  input wire logic reset, // Async reset
  ubw_link_if.far lnk, // Shared serial line
  input wire logic [15:0] baud_div, // Clocks per bit
  input wire logic is_slave, // Act as slave
  input wire logic [7:0] own_code, // Own select code
  input wire logic send_req, // Send pulse
  input wire logic [7:0] send_data, // Data or select code
  input wire logic send_addr, // Address frame
  output logic send_busy, // Frame in flight
  output logic recv_valid, // Accepted frame pulse
  output logic [7:0] recv_data, // Received data
  output logic recv_ninth, // Received ninth bit
  output logic selected // Slave wake filter cleared
);
  logic f_txd;
  logic f_done;
  logic [8:0] f_data;
  logic tx_go;
  logic tx_out_q;
  logic tx_oe_q;

  // A waking slave may only answer once selected
  assign tx_go = send_req && (!is_slave || selected);
  assign lnk.far_tx_out = tx_out_q;
  assign lnk.far_tx_oe = tx_oe_q;

  ubw_frame u_frame (
    .mclk(mclk),
    .reset(reset),
    .div(baud_div),
    .nine(1'b1),
    .par_en(1'b0),
    .par_even(1'b0),
    .stop2(1'b0),
    .tx_start(tx_go),
    .tx_data({send_addr, send_data}),
    .tx_busy(send_busy),
    .txd(f_txd),
    .rx_pin(lnk.far_rx),
    .rx_done(f_done),
    .rx_data(f_data),
    .rx_perr(),
    .rx_ferr()
  );

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tx_out_q <= 1'b1;
      tx_oe_q <= 1'b0;
    end else if (is_slave) begin
      tx_out_q <= 1'b0;
      tx_oe_q <= !f_txd;
    end else begin
      tx_out_q <= f_txd;
      tx_oe_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      selected <= 1'b0;
    end else if (f_done && is_slave && f_data[8]) begin
      selected <= (f_data[7:0] == own_code);
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      recv_valid <= 1'b0;
      recv_data <= 8'h00;
      recv_ninth <= 1'b0;
    end else begin
      recv_valid <= f_done && (!is_slave || selected || f_data[8]);
      if (f_done) begin
        recv_data <= f_data[7:0];
        recv_ninth <= f_data[8];
      end
    end
  end
endmodule
`default_nettype wire

// ---- design/ubw_dev.sv ----
`timescale 1ns/1ps
`default_nettype none
module ubw_dev (
  input wire logic mclk, // Clock, 125 MHz
  input wire logic reset, // Async reset, active high
  input wire logic [4:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  output logic irq, // Level interrupt
  ubw_link_if.dev lnk // Serial line
);
  logic [1:0] frame_mode_sel_q;
  logic wake_filter_en_q;
  logic tx_ninth_bit_q;
  logic parity_en_q;
  logic even_q;
  logic rx_ninth_bit_q;
  logic perr_q;
  logic ferr_q;
  logic [7:0] rx_buf_q;
  logic stop_len_sel_q;
  logic open_drain_ctl_q;
  logic [15:0] baud_q;
  logic [2:0] stat_q;
  logic [2:0] stat_d;
  logic [2:0] mask_q;
  logic busy_prev_q;
  logic tx_out_q;
  logic tx_oe_q;
  logic acc;
  logic wr_acc;
  logic uart_on;
  logic nine;
  logic tx_start;
  logic rx_keep;
  logic [2:0] ev;
  logic [31:0] rdata_d;
  logic f_busy;
  logic f_txd;
  logic f_done;
  logic [8:0] f_data;
  logic f_perr;
  logic f_ferr;

  // The access takes effect at the edge where waitrequest is seen low
  assign acc = (avs_read || avs_write) && !avs_waitrequest;
  assign wr_acc = acc && avs_write;
  assign uart_on = frame_mode_sel_q[1];
  assign nine = (frame_mode_sel_q == ubw_pkg::MODE_9BIT);
  // A write to the data buffer while a frame is in flight is dropped
  assign tx_start = wr_acc && (avs_address == ubw_pkg::OFS_DATA) && uart_on && !f_busy;
  // Filter applies in 9-bit framing only
  assign rx_keep = f_done && uart_on &&
                   (!(nine && wake_filter_en_q) || f_data[8]);
  assign lnk.dev_tx_out = tx_out_q;
  assign lnk.dev_tx_oe = tx_oe_q;

  ubw_frame u_frame (
    .mclk(mclk),
    .reset(reset),
    .div(baud_q),
    .nine(nine),
    .par_en(parity_en_q && !nine),
    .par_even(even_q),
    .stop2(stop_len_sel_q),
    .tx_start(tx_start),
    .tx_data({tx_ninth_bit_q, avs_writedata[7:0]}),
    .tx_busy(f_busy),
    .txd(f_txd),
    .rx_pin(lnk.dev_rx),
    .rx_done(f_done),
    .rx_data(f_data),
    .rx_perr(f_perr),
    .rx_ferr(f_ferr)
  );

  // Avalon handshake: one wait cycle, then one cycle with waitrequest low
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
    end else if (!avs_waitrequest) begin
      avs_waitrequest <= 1'b1;
    end else if (avs_read || avs_write) begin
      avs_waitrequest <= 1'b0;
    end
  end

  always_comb begin
    rdata_d = 32'h00000000;
    unique case (avs_address)
      ubw_pkg::OFS_MODE0: begin
        rdata_d[ubw_pkg::M0_SEL_LO +: 2] = frame_mode_sel_q;
        rdata_d[ubw_pkg::M0_WAKE] = wake_filter_en_q;
        rdata_d[ubw_pkg::M0_TX9] = tx_ninth_bit_q;
      end
      ubw_pkg::OFS_CTL: begin
        rdata_d[ubw_pkg::CT_PAR_EN] = parity_en_q;
        rdata_d[ubw_pkg::CT_EVEN] = even_q;
        rdata_d[ubw_pkg::CT_PERR] = perr_q;
        rdata_d[ubw_pkg::CT_FERR] = ferr_q;
        rdata_d[ubw_pkg::CT_RX9] = rx_ninth_bit_q;
      end
      ubw_pkg::OFS_DATA: begin
        rdata_d[7:0] = rx_buf_q;
      end
      ubw_pkg::OFS_MODE2: begin
        rdata_d[ubw_pkg::M2_STOP] = stop_len_sel_q;
        rdata_d[ubw_pkg::M2_OD] = open_drain_ctl_q;
        rdata_d[ubw_pkg::M2_BUSY] = f_busy;
      end
      ubw_pkg::OFS_BAUD: begin
        rdata_d[15:0] = baud_q;
      end
      ubw_pkg::OFS_STAT: begin
        rdata_d[ubw_pkg::IRQ_W - 1:0] = stat_q;
      end
      ubw_pkg::OFS_MASK: begin
        rdata_d[ubw_pkg::IRQ_W - 1:0] = mask_q;
      end
      default: begin
        rdata_d = 32'h00000000;
      end
    endcase
  end

  // Read data is latched as waitrequest drops and holds through the accept edge
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rdata_d;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      frame_mode_sel_q <= ubw_pkg::MODE_OFF;
      wake_filter_en_q <= 1'b0;
      tx_ninth_bit_q <= 1'b0;
    end else if (wr_acc && avs_address == ubw_pkg::OFS_MODE0) begin
      frame_mode_sel_q <= avs_writedata[ubw_pkg::M0_SEL_LO +: 2];
      wake_filter_en_q <= avs_writedata[ubw_pkg::M0_WAKE];
      tx_ninth_bit_q <= avs_writedata[ubw_pkg::M0_TX9];
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      parity_en_q <= 1'b0;
      even_q <= 1'b0;
    end else if (wr_acc && avs_address == ubw_pkg::OFS_CTL) begin
      parity_en_q <= avs_writedata[ubw_pkg::CT_PAR_EN];
      even_q <= avs_writedata[ubw_pkg::CT_EVEN];
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      stop_len_sel_q <= 1'b0;
      open_drain_ctl_q <= 1'b0;
      baud_q <= ubw_pkg::BAUD_RST;
    end else if (wr_acc && avs_address == ubw_pkg::OFS_MODE2) begin
      stop_len_sel_q <= avs_writedata[ubw_pkg::M2_STOP];
      open_drain_ctl_q <= avs_writedata[ubw_pkg::M2_OD];
    end else if (wr_acc && avs_address == ubw_pkg::OFS_BAUD) begin
      baud_q <= avs_writedata[15:0];
    end
  end

  // Filtered frames never reach the buffer, so the last kept frame survives
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rx_buf_q <= 8'h00;
      rx_ninth_bit_q <= 1'b0;
      perr_q <= 1'b0;
      ferr_q <= 1'b0;
    end else if (rx_keep) begin
      rx_buf_q <= f_data[7:0];
      rx_ninth_bit_q <= nine && f_data[8];
      perr_q <= f_perr;
      ferr_q <= f_ferr;
    end
  end

  // Open-drain: drive only the low level, let the pull-up make the high
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tx_out_q <= 1'b1;
      tx_oe_q <= 1'b0;
    end else if (open_drain_ctl_q) begin
      tx_out_q <= 1'b0;
      tx_oe_q <= !f_txd;
    end else begin
      tx_out_q <= f_txd;
      tx_oe_q <= uart_on || f_busy;
    end
  end

  always_comb begin
    ev = 3'h0;
    ev[ubw_pkg::IRQ_RX] = rx_keep;
    ev[ubw_pkg::IRQ_TX] = busy_prev_q && !f_busy;
    ev[ubw_pkg::IRQ_ERR] = rx_keep && (f_perr || f_ferr);
    stat_d = stat_q;
    if (wr_acc && avs_address == ubw_pkg::OFS_STAT) begin
      stat_d = stat_q & ~avs_writedata[ubw_pkg::IRQ_W - 1:0];
    end
    // A new event wins over a clear in the same cycle
    stat_d = stat_d | ev;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      stat_q <= 3'h0;
      busy_prev_q <= 1'b0;
      irq <= 1'b0;
    end else begin
      stat_q <= stat_d;
      busy_prev_q <= f_busy;
      irq <= |(stat_d & mask_q);
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mask_q <= ubw_pkg::MASK_RST;
    end else if (wr_acc && avs_address == ubw_pkg::OFS_MASK) begin
      mask_q <= avs_writedata[ubw_pkg::IRQ_W - 1:0];
    end
  end
endmodule
`default_nettype wire

// ---- verification/ubw_link_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module ubw_link_checker #(
  parameter int BAUD = 8 // Clocks per bit on both ends
) (
  input wire logic mclk, // Clock
  input wire logic reset, // Async reset
  input wire logic dev_tx_out, // Device drive level
  input wire logic dev_tx_oe, // Device drive enable
  input wire logic far_tx_out, // Far drive level
  input wire logic far_tx_oe, // Far drive enable
  input wire logic dev_rx, // Line into the device
  input wire logic far_rx // Line into the far end
);
  // A low run longer than start plus nine zero bits means a missing stop bit
  localparam int LOW_MAX = 10 * BAUD;
  logic [15:0] dlow_q;
  logic [15:0] flow_q;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      dlow_q <= 16'h0000;
    end else begin
      dlow_q <= far_rx ? 16'h0000 : dlow_q + 16'h0001;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      flow_q <= 16'h0000;
    end else begin
      flow_q <= dev_rx ? 16'h0000 : flow_q + 16'h0001;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // Repeat counts are fixed at the bench's eight clocks per bit
  sequence s_dev_bit_high;
    far_rx [*8];
  endsequence
  sequence s_far_bit_high;
    dev_rx [*8];
  endsequence

  property p_dev_idle;
    $fell(reset) |-> far_rx && !dev_tx_oe;
  endproperty
  property p_far_idle;
    $fell(reset) |-> dev_rx && !far_tx_oe;
  endproperty
  property p_dev_low_whole;
    $rose(far_rx) |-> (int'(dlow_q) % BAUD) == 0;
  endproperty
  property p_far_low_whole;
    $rose(dev_rx) |-> (int'(flow_q) % BAUD) == 0;
  endproperty
  property p_dev_low_max;
    int'(dlow_q) <= LOW_MAX;
  endproperty
  property p_far_low_max;
    int'(flow_q) <= LOW_MAX;
  endproperty
  property p_dev_high_min;
    $rose(far_rx) |-> s_dev_bit_high;
  endproperty
  property p_far_high_min;
    $rose(dev_rx) |-> s_far_bit_high;
  endproperty

  a_dev_idle: assert property (p_dev_idle)
    else $error("device line not idle after reset");
  a_far_idle: assert property (p_far_idle)
    else $error("far line not idle after reset");
  a_dev_low_whole: assert property (p_dev_low_whole)
    else $error("device low run not whole bits");
  a_far_low_whole: assert property (p_far_low_whole)
    else $error("far low run not whole bits");
  a_dev_low_max: assert property (p_dev_low_max)
    else $error("device frame without stop bit");
  a_far_low_max: assert property (p_far_low_max)
    else $error("far frame without stop bit");
  a_dev_high_min: assert property (p_dev_high_min)
    else $error("device high bit too short");
  a_far_high_min: assert property (p_far_high_min)
    else $error("far high bit too short");
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic is_slave = 1'b0;
  logic send_req = 1'b0;
  logic [7:0] send_data = 8'h00;
  logic send_addr = 1'b0;
  logic send_busy;
  logic recv_valid;
  logic [7:0] recv_data;
  logic recv_ninth;
  logic selected;
  logic [31:0] rd;
  logic [4:0] prow [6] = '{5'h18, 5'h1E, 5'h10, 5'h16, 5'h00, 5'h01};
  int n_errors = 0;
  int num_checks = 0;
  int n_recv = 0;

  ubw_link_if lnk ();
  always #4 mclk = ~mclk;
  always @(posedge mclk)
    if (recv_valid === 1'b1) n_recv <= n_recv + 1;

  ubw_dev ubw_dev_i (.mclk(mclk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .lnk(lnk.dev));
  ubw_far ubw_far_i (.mclk(mclk), .reset(reset), .lnk(lnk.far), .baud_div(16'h0008),
    .is_slave(is_slave), .own_code(8'h3C), .send_req(send_req), .send_data(send_data),
    .send_addr(send_addr), .send_busy(send_busy), .recv_valid(recv_valid),
    .recv_data(recv_data), .recv_ninth(recv_ninth), .selected(selected));
  ubw_link_checker #(.BAUD(8)) ubw_link_checker_i (.mclk(mclk), .reset(reset),
    .dev_tx_out(lnk.dev_tx_out), .dev_tx_oe(lnk.dev_tx_oe), .far_tx_out(lnk.far_tx_out),
    .far_tx_oe(lnk.far_tx_oe), .dev_rx(lnk.dev_rx), .far_rx(lnk.far_rx));

  function automatic logic [31:0] m0(input logic t9, input logic wk, input logic [1:0] sel);
    m0 = 32'h0000_0000;
    m0[ubw_pkg::M0_TX9] = t9;
    m0[ubw_pkg::M0_WAKE] = wk;
    m0[ubw_pkg::M0_SEL_LO +: 2] = sel;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Holds the request until waitrequest is seen low at a rising edge
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) chk("bus answer", 32'h0, 32'h1);
    @(posedge mclk);
  endtask

  task automatic rchk(input string nm, input logic [4:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask

  task automatic fsend(input logic a9, input logic [7:0] d);
    send_addr <= a9;
    send_data <= d;
    send_req <= 1'b1;
    @(posedge mclk);
    send_req <= 1'b0;
  endtask

  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    chk("irq", 32'h1, {31'h0, irq});
  endtask

  task automatic wait_recv;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (recv_valid !== 1'b1 && n < 3000);
    chk("far recv", 32'h1, {31'h0, recv_valid});
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge mclk);
    n_errors++;
    conclude();
  end

  initial begin
    int n;
    logic [7:0] d;
    logic nin;
    logic [4:0] p;
    d = 8'hB7;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    rchk("mode0 reset", ubw_pkg::OFS_MODE0, 32'h0);
    rchk("ctl reset", ubw_pkg::OFS_CTL, 32'h0);
    rchk("mode2 reset", ubw_pkg::OFS_MODE2, 32'h0);
    rchk("baud reset", ubw_pkg::OFS_BAUD, 32'(ubw_pkg::BAUD_RST));
    rchk("stat reset", ubw_pkg::OFS_STAT, 32'h0);
    rchk("mask reset", ubw_pkg::OFS_MASK, 32'(ubw_pkg::MASK_RST));
    acc(1'b1, 5'h1C, 32'hFFFF_FFFF);
    rchk("unmapped", 5'h1C, 32'h0);
    acc(1'b1, ubw_pkg::OFS_BAUD, 32'h0000_0008);
    acc(1'b1, ubw_pkg::OFS_MASK, 32'h0000_0005);
    acc(1'b1, ubw_pkg::OFS_MODE0, m0(1'b0, 1'b1, ubw_pkg::MODE_9BIT));
    // Data frame must be filtered while the wake filter is on
    fsend(1'b0, 8'h5A);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (send_busy !== 1'b0 && n < 3000);
    repeat (24) @(posedge mclk);
    rchk("filtered stat", ubw_pkg::OFS_STAT, 32'h0);
    chk("filtered irq", 32'h0, {31'h0, irq});
    fsend(1'b1, 8'h3C);
    wait_irq();
    rchk("addr ninth", ubw_pkg::OFS_CTL, 32'h0000_0080);
    rchk("addr data", ubw_pkg::OFS_DATA, 32'h0000_003C);
    acc(1'b1, ubw_pkg::OFS_STAT, 32'h0000_0007);
    rchk("stat cleared", ubw_pkg::OFS_STAT, 32'h0);
    chk("irq cleared", 32'h0, {31'h0, irq});
    acc(1'b1, ubw_pkg::OFS_MODE0, m0(1'b0, 1'b0, ubw_pkg::MODE_9BIT));
    fsend(1'b0, 8'hA5);
    wait_irq();
    rchk("data ninth", ubw_pkg::OFS_CTL, 32'h0);
    rchk("data byte", ubw_pkg::OFS_DATA, 32'h0000_00A5);
    acc(1'b1, ubw_pkg::OFS_STAT, 32'h0000_0007);
    acc(1'b1, ubw_pkg::OFS_MODE0, m0(1'b0, 1'b0, ubw_pkg::MODE_8BIT));
    // Far ninth bit lands where the parity or stop bit is expected
    for (int i = 0; i < 6; i++) begin
      p = prow[i];
      acc(1'b1, ubw_pkg::OFS_CTL, {30'h0, p[3], p[4]});
      nin = p[4] ? ((p[3] ? ^d : ~^d) ^ p[2]) : !p[0];
      fsend(nin, d);
      wait_irq();
      acc(1'b0, ubw_pkg::OFS_CTL, 32'h0);
      chk("parity ctl", {28'h0, p[0], p[1], p[3], p[4]}, rd & 32'h0000_000F);
      rchk("parity data", ubw_pkg::OFS_DATA, {24'h0, d});
      acc(1'b1, ubw_pkg::OFS_STAT, 32'h0000_0007);
    end
    // Second reset: the far end becomes a selectable slave
    reset <= 1'b1;
    is_slave <= 1'b1;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    acc(1'b1, ubw_pkg::OFS_BAUD, 32'h0000_0008);
    acc(1'b1, ubw_pkg::OFS_MODE2, 32'h0000_0003);
    acc(1'b1, ubw_pkg::OFS_MODE0, m0(1'b1, 1'b0, ubw_pkg::MODE_9BIT));
    acc(1'b1, ubw_pkg::OFS_DATA, 32'h0000_003C);
    rchk("busy", ubw_pkg::OFS_MODE2, 32'h0000_0007);
    acc(1'b1, ubw_pkg::OFS_DATA, 32'h0000_0011);
    wait_recv();
    chk("far addr", 32'h0000_013C, {23'h0, recv_ninth, recv_data});
    n = 0;
    do begin
      acc(1'b0, ubw_pkg::OFS_STAT, 32'h0);
      n++;
    end while (rd[ubw_pkg::IRQ_TX] !== 1'b1 && n < 200);
    chk("tx done", 32'h1, {31'h0, rd[ubw_pkg::IRQ_TX]});
    chk("masked irq", 32'h0, {31'h0, irq});
    chk("selected", 32'h1, {31'h0, selected});
    acc(1'b1, ubw_pkg::OFS_MASK, 32'h0000_0002);
    rchk("mask", ubw_pkg::OFS_MASK, 32'h0000_0002);
    chk("unmasked irq", 32'h1, {31'h0, irq});
    acc(1'b1, ubw_pkg::OFS_STAT, 32'h0000_0007);
    rchk("tx stat cleared", ubw_pkg::OFS_STAT, 32'h0);
    chk("tx irq cleared", 32'h0, {31'h0, irq});
    acc(1'b1, ubw_pkg::OFS_MASK, 32'h0000_0001);
    acc(1'b1, ubw_pkg::OFS_MODE0, m0(1'b0, 1'b0, ubw_pkg::MODE_9BIT));
    acc(1'b1, ubw_pkg::OFS_DATA, 32'h0000_0077);
    wait_recv();
    @(posedge mclk);
    chk("far data", 32'h0000_0077, {23'h0, recv_ninth, recv_data});
    chk("busy write dropped", 32'h2, n_recv);
    fsend(1'b0, 8'h99);
    wait_irq();
    rchk("reply ninth", ubw_pkg::OFS_CTL, 32'h0);
    rchk("reply data", ubw_pkg::OFS_DATA, 32'h0000_0099);
    conclude();
  end
endmodule
`default_nettype wire
